//--- inc/nand_host_pkg.sv
// Constants, opcodes and carrier types for the NAND host sequencer.
// Assumes a 50 MHz system clock and an asynchronous strobe-driven flash.
`default_nettype none
package nand_host_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and strobe timing
  localparam int CLK_NS = 20;
  localparam int STROBE_LOW_NS = 25;   // Write strobe low time
  localparam int STROBE_HIGH_NS = 15;  // Strobe high time between cycles
  localparam int READ_ACCESS_DELAY_NS = 25;
  localparam int BUSY_ONSET_NS = 100;  // Wait before trusting ready/busy
  localparam int LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_ACCESS_DELAY_CYC = (READ_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_LOW_CYC = READ_ACCESS_DELAY_CYC + 1;
  localparam int BUSY_ONSET_CYC = (BUSY_ONSET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] WR_LAST = 4'(LOW_CYC + HIGH_CYC + 1);
  localparam logic [3:0] RD_LAST = 4'(RD_LOW_CYC + HIGH_CYC + 1);
  localparam logic [3:0] WR_LOW_END = 4'(LOW_CYC);
  localparam logic [3:0] RD_LOW_END = 4'(RD_LOW_CYC);
  localparam logic [3:0] RD_SAMPLE = 4'(RD_LOW_CYC + 1);
  localparam logic [3:0] WB_LAST = 4'(BUSY_ONSET_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int BLOCKS = 1024;
  localparam int PAGES_PER_BLOCK = 64;
  localparam logic [11:0] PAGE_BYTES = 12'd2112;
  localparam int MAIN_BYTES = 2048;
  localparam int SPARE_BYTES = 64;
  localparam logic [11:0] PAGE_WORDS = 12'd1056;
  localparam int MAIN_WORDS = 1024;
  localparam int SPARE_WORDS = 32;
  localparam logic [1:0] ADDR_FIRST_FULL = 2'd0;
  localparam logic [1:0] ADDR_FIRST_ROW = 2'd2;
  localparam logic [1:0] ADDR_LAST = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  // Command bytes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;

  ////////////////////////////////////////////////////////////////////////////
  // Data path
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10
  } op_t;

  typedef struct packed {
    op_t op;
    logic [11:0] col;
    logic [15:0] row;
    logic [11:0] len;
  } req_t;

endpackage
`default_nettype wire

//--- logic/nand_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module nand_fifo #(
  parameter int WIDTH = nand_host_pkg::WORD_W,
  parameter int DEPTH = nand_host_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic s_valid_i,
  input wire logic [WIDTH-1:0] s_data_i,
  output logic s_ready_o,
  // Drain side
  output logic m_valid_o,
  output logic [WIDTH-1:0] m_data_o,
  input wire logic m_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  // Ready is registered so the fill side sees a flop
  assign push = s_valid_i && s_ready_o;
  assign pop = m_ready_i && m_valid_o;
  assign m_valid_o = count_q != '0;
  assign m_data_o = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Occupancy, pointers and full flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= '0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      s_ready_o <= 1'b0;
    end else begin
      count_q <= count_d;
      s_ready_o <= count_d < (AW+1)'(DEPTH);
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Storage needs no reset; empty entries are never shown
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= s_data_i;
    end
  end

endmodule
`default_nettype wire

//--- logic/nand_addr_cycle.sv
// Address cycle formatter: picks the bus value for one of four address cycles.
// Assumes column and row are already within the page and array limits.
`timescale 1ns/100ps
`default_nettype none
module nand_addr_cycle (
  // Bus width and cycle index
  input wire logic bus16_i,
  input wire logic [1:0] idx_i,
  // Address parts
  input wire logic [11:0] col_i,
  input wire logic [15:0] row_i,
  // Value for the shared data pins
  output logic [15:0] value_o
);

  // Unused bit positions and pins 8-15 are always driven low
  always_comb begin
    case (idx_i)
      2'd0: value_o = {8'h00, col_i[7:0]};
      2'd1: value_o = bus16_i ? {13'h0000, col_i[10:8]} : {12'h000, col_i[11:8]};
      2'd2: value_o = {8'h00, row_i[7:0]};
      2'd3: value_o = {8'h00, row_i[15:8]};
      default: value_o = 16'h0000;
    endcase
  end

endmodule
`default_nettype wire

//--- logic/nand_host.sv
// Host sequencer that drives a raw NAND flash through its strobe pins.
// Assumes pin inputs are synchronous to clk_i and the flash is powered up.
//
// Summary of operation
// - Device latches pins on write strobe rise; host drives them before.
// - Commands, addresses and data share one 8 or 16 bit bus.
// - Narrow bus: cycles one and two carry column bits A0 to A11.
// - Narrow bus: cycles three and four carry row bits A12 to A27.
// - Host drives unassigned address bit positions low.
// - Wide bus: column A0-A10 in cycles 1-2, row A11-A26 in 3-4.
// - Wide bus: pins 8 to 15 held low in every address cycle.
// - Page read is 00h, four address cycles, then 30h.
`timescale 1ns/100ps
`default_nettype none
module nand_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration
  input wire logic bus16_i,
  // Request port
  input wire logic req_valid_i,
  input wire nand_host_pkg::req_t req_i,
  output logic req_ready_o,
  // Program data in
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_ready_o,
  // Read data out and status
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic done_o,
  output logic busy_o,
  // Flash pins
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic wp_n_o,
  output logic [15:0] shared_data_pins_o,
  output logic shared_data_pins_oe_o,
  input wire logic [15:0] shared_data_pins_i,
  input wire logic ready_busy_n_i
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD1 = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WDATA = 4'b0011,
    ST_CMD2 = 4'b0100,
    ST_WB = 4'b0101,
    ST_WAIT = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_DONE = 4'b1000
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Words left in the page from a column, limiting the transfer length
  function automatic logic [11:0] clamp_len(input logic wide, input logic [11:0] col,
                                            input logic [11:0] len);
    logic [11:0] limit;
    logic [11:0] room;
    limit = wide ? nand_host_pkg::PAGE_WORDS : nand_host_pkg::PAGE_BYTES;
    room = (col < limit) ? limit - col : 12'h000;
    clamp_len = (len < room) ? len : room;
  endfunction

  // Command byte for the opening or closing command cycle
  function automatic logic [7:0] cmd_byte(input nand_host_pkg::op_t op, input logic second);
    case (op)
      nand_host_pkg::OP_PROG:
        cmd_byte = second ? nand_host_pkg::CMD_PROG_GO : nand_host_pkg::CMD_PROG_SETUP;
      nand_host_pkg::OP_ERASE:
        cmd_byte = second ? nand_host_pkg::CMD_ERASE_GO : nand_host_pkg::CMD_ERASE_SETUP;
      default:
        cmd_byte = second ? nand_host_pkg::CMD_READ_GO : nand_host_pkg::CMD_READ_SETUP;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  state_t state_q;
  nand_host_pkg::req_t req_q;
  logic bus16_q;
  logic [3:0] cyc_q;
  logic [3:0] wb_q;
  logic [1:0] aidx_q;
  logic [11:0] left_q;
  logic [15:0] addr_value;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic accept;
  logic is_read_cyc;
  logic bus_cyc;
  logic cyc_end;
  logic stall;

  assign accept = req_valid_i && req_ready_o;
  assign is_read_cyc = state_q == ST_RDATA;
  assign bus_cyc = state_q inside {ST_CMD1, ST_ADDR, ST_WDATA, ST_CMD2, ST_RDATA};
  assign cyc_end = cyc_q == (is_read_cyc ? nand_host_pkg::RD_LAST : nand_host_pkg::WR_LAST);
  // A data cycle waits at its setup step until the FIFO has a word
  assign stall = state_q == ST_WDATA && cyc_q == 4'h0 && !fifo_valid;
  assign fifo_pop = state_q == ST_WDATA && cyc_q == 4'h0 && fifo_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Program data buffer

  nand_fifo #(
    .WIDTH(nand_host_pkg::WORD_W),
    .DEPTH(nand_host_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .s_valid_i(wr_valid_i),
    .s_data_i(wr_data_i),
    .s_ready_o(wr_ready_o),
    .m_valid_o(fifo_valid),
    .m_data_o(fifo_data),
    .m_ready_i(fifo_pop)
  );

  // Address cycle value for the current index
  nand_addr_cycle u_addr (
    .bus16_i(bus16_q),
    .idx_i(aidx_q),
    .col_i(req_q.col),
    .row_i(req_q.row),
    .value_o(addr_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request capture

  // Length is clamped so reads and programs never run past the page end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_q <= '0;
      bus16_q <= 1'b0;
    end else if (accept) begin
      req_q <= req_i;
      req_q.len <= clamp_len(bus16_i, req_i.col, req_i.len);
      bus16_q <= bus16_i;
    end
  end

  // Ready only while idle and the flash reports ready, e.g. after power-up
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= state_q == ST_IDLE && ready_busy_n_i && !accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle step counter

  // Every bus cycle: setup step, strobe low window, strobe high window
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cyc_q <= 4'h0;
    end else if (!bus_cyc || cyc_end) begin
      cyc_q <= 4'h0;
    end else if (!stall) begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      aidx_q <= 2'd0;
      left_q <= 12'h000;
      wb_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_CMD1;
          end
        end
        ST_CMD1: begin
          if (cyc_end) begin
            state_q <= ST_ADDR;
            // Erase sends only the two row cycles
            aidx_q <= (req_q.op == nand_host_pkg::OP_ERASE) ?
                      nand_host_pkg::ADDR_FIRST_ROW : nand_host_pkg::ADDR_FIRST_FULL;
            left_q <= req_q.len;
          end
        end
        ST_ADDR: begin
          // Four cycles are sent, only the two row cycles for erase; extras would be ignored anyway
          if (cyc_end) begin
            if (aidx_q == nand_host_pkg::ADDR_LAST) begin
              state_q <= (req_q.op == nand_host_pkg::OP_PROG && left_q != 12'h000) ?
                         ST_WDATA : ST_CMD2;
            end else begin
              aidx_q <= aidx_q + 2'd1;
            end
          end
        end
        ST_WDATA: begin
          if (cyc_end) begin
            left_q <= left_q - 12'h001;
            if (left_q == 12'h001) begin
              state_q <= ST_CMD2;
            end
          end
        end
        ST_CMD2: begin
          if (cyc_end) begin
            state_q <= ST_WB;
            wb_q <= 4'h0;
          end
        end
        ST_WB: begin
          // Ready/busy takes a while to fall; do not trust it earlier
          wb_q <= wb_q + 4'h1;
          if (wb_q == nand_host_pkg::WB_LAST) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ready_busy_n_i) begin
            state_q <= (req_q.op == nand_host_pkg::OP_READ && left_q != 12'h000) ?
                       ST_RDATA : ST_DONE;
          end
        end
        ST_RDATA: begin
          if (cyc_end) begin
            left_q <= left_q - 12'h001;
            if (left_q == 12'h001) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip select, latch enables and write protect

  // Select is held low for the whole operation; strobes only move inside it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      wp_n_o <= 1'b0;
    end else begin
      ce_n_o <= state_q == ST_IDLE || state_q == ST_DONE;
      cle_o <= state_q == ST_CMD1 || state_q == ST_CMD2;
      ale_o <= state_q == ST_ADDR;
      // Protection is lifted only while a program or erase is in flight
      wp_n_o <= state_q != ST_IDLE && state_q != ST_DONE &&
                req_q.op != nand_host_pkg::OP_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes

  // Low windows come one step after the setup step, so data leads the edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end else begin
      we_n_o <= !(bus_cyc && !is_read_cyc && !stall && cyc_q >= 4'h1 &&
                  cyc_q <= nand_host_pkg::WR_LOW_END);
      read_strobe_n_o <= !(is_read_cyc && cyc_q >= 4'h1 &&
                           cyc_q <= nand_host_pkg::RD_LOW_END);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared data pins

  // Value is set at the setup step and held until the next cycle's setup
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shared_data_pins_o <= 16'h0000;
      shared_data_pins_oe_o <= 1'b0;
    end else begin
      shared_data_pins_oe_o <= bus_cyc && !is_read_cyc;
      if (cyc_q == 4'h0) begin
        case (state_q)
          ST_CMD1: shared_data_pins_o <= {8'h00, cmd_byte(req_q.op, 1'b0)};
          ST_CMD2: shared_data_pins_o <= {8'h00, cmd_byte(req_q.op, 1'b1)};
          ST_ADDR: shared_data_pins_o <= addr_value;
          ST_WDATA: begin
            if (fifo_valid) begin
              // Narrow bus leaves the upper pins low
              shared_data_pins_o <= bus16_q ? fifo_data : {8'h00, fifo_data[7:0]};
            end
          end
          default: shared_data_pins_o <= shared_data_pins_o;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and status

  // Sampled at the last low step of the read strobe, after the access delay
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
    end else begin
      rd_valid_o <= is_read_cyc && cyc_q == nand_host_pkg::RD_SAMPLE;
      if (is_read_cyc && cyc_q == nand_host_pkg::RD_SAMPLE) begin
        rd_data_o <= bus16_q ? shared_data_pins_i : {8'h00, shared_data_pins_i[7:0]};
      end
    end
  end

  // Done pulses once per request; busy covers everything between
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= state_q == ST_DONE;
      busy_o <= state_q != ST_IDLE;
    end
  end

endmodule
`default_nettype wire

//--- test/nand_host_sva.sv
// Pin-level checker for the NAND host sequencer.
// Assumes one clock and a synchronous active-high reset; bound to nand_host.
`timescale 1ns/100ps
`default_nettype none
module nand_host_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Status
  input wire logic req_ready_o,
  input wire logic done_o,
  // Flash pins
  input wire logic ce_n_o,
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic we_n_o,
  input wire logic read_strobe_n_o,
  input wire logic wp_n_o,
  input wire logic [15:0] shared_data_pins_o,
  input wire logic shared_data_pins_oe_o,
  input wire logic ready_busy_n_i
);
  ////////////////////////////////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Chip select may lag done by up to two register stages
  ce_release_a: assert property (done_o |-> ##[0:2] ce_n_o)
    else $error("chip select still low after done");
  strobe_select_a: assert property ((!we_n_o || !read_strobe_n_o) |-> !ce_n_o)
    else $error("strobe pulsed without chip select");
  we_pulse_a: assert property ($fell(we_n_o) |-> ##1 !we_n_o ##1 we_n_o)
    else $error("write strobe low time wrong");
  // Data must be settled through the low phase and the rising edge
  we_data_a: assert property ((!we_n_o || $rose(we_n_o)) |->
    shared_data_pins_oe_o && $stable(shared_data_pins_o))
    else $error("data pins moved around write strobe");
  read_pulse_a: assert property ($fell(read_strobe_n_o) |->
    !read_strobe_n_o[*3] ##1 read_strobe_n_o)
    else $error("read strobe low time wrong");
  read_float_a: assert property (!read_strobe_n_o |->
    !shared_data_pins_oe_o && we_n_o && !cle_o && !ale_o && !wp_n_o)
    else $error("host drives or latches during read");
  latch_excl_a: assert property (cle_o |-> !ale_o)
    else $error("command and address latch together");
  addr_upper_a: assert property ((ale_o && !we_n_o) |->
    shared_data_pins_o[15:8] == 8'h00)
    else $error("upper pins not low in address cycle");
  wp_cmd_a: assert property ((cle_o && !we_n_o &&
    shared_data_pins_o[7:0] inside {8'h80, 8'h10, 8'h60, 8'hd0}) |-> wp_n_o)
    else $error("program or erase sent while protected");
  busy_hold_a: assert property (!ready_busy_n_i |=> !req_ready_o)
    else $error("request taken while flash busy");
  read_ready_a: assert property ($fell(read_strobe_n_o) |-> $past(ready_busy_n_i))
    else $error("read strobe while flash busy");

  c_read: cover property ($fell(read_strobe_n_o));
  c_erase: cover property (cle_o && !we_n_o && shared_data_pins_o[7:0] == 8'hd0);
  c_done: cover property (done_o);
endmodule

bind nand_host nand_host_sva nand_host_sva_i (
  .clk_i(clk_i), .srst_i(srst_i), .req_ready_o(req_ready_o), .done_o(done_o),
  .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
  .read_strobe_n_o(read_strobe_n_o), .wp_n_o(wp_n_o),
  .shared_data_pins_o(shared_data_pins_o), .shared_data_pins_oe_o(shared_data_pins_oe_o),
  .ready_busy_n_i(ready_busy_n_i)
);
`default_nettype wire

//--- test/nand_flash_model.sv
// Behavioural raw flash on the far side of the host sequencer.
// Assumes the bench resolves the shared pins and pulls ready/busy up.
`timescale 1ns/100ps
`default_nettype none
module nand_flash_model #(
  parameter int BUSY_NS = 400
) (
  // Strobes and mode
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic bus16_i,
  // Shared pins
  input wire logic [15:0] pins_i,
  output logic [15:0] data_o,
  output logic pull_low_o
);
  logic [15:0] cmd_q[$];
  logic [15:0] addr_q[$];
  logic [15:0] data_q[$];
  logic [15:0] w;
  int commits = 0;
  int col = 0;
  event go;

  initial begin
    data_o = 16'h5a5a;
    pull_low_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch on the write strobe rise, only while selected
  always @(posedge we_n_i) begin
    if (ce_n_i === 1'b0) begin
      if (cle_i) begin
        cmd_q.push_back(pins_i);
        if (pins_i[7:0] == 8'h30 || (wp_n_i && pins_i[7:0] inside {8'h10, 8'hd0})) begin
          if (pins_i[7:0] != 8'h30) commits++;
          ->go;
        end
      end else if (ale_i) begin
        addr_q.push_back(pins_i);
        // Only the first two cycles set the column; extras change nothing
        if (addr_q.size() == 2) begin
          col = bus16_i ? {addr_q[1][2:0], addr_q[0][7:0]} : {addr_q[1][3:0], addr_q[0][7:0]};
        end
      end else begin
        data_q.push_back(pins_i);
      end
    end
  end

  // Busy pulse after each accepted operation
  always begin
    @go;
    pull_low_o = 1'b1;
    #BUSY_NS;
    pull_low_o = 1'b0;
  end

  // Each read pulse gives the next column after the access delay
  always @(negedge read_strobe_n_i) begin
    if (ce_n_i === 1'b0 && !pull_low_o) begin
      #(nand_host_pkg::READ_ACCESS_DELAY_NS);
      w = 16'(col * 261 + 15450);
      data_o = bus16_i ? w : {~data_o[15:8], w[7:0]};
      col++;
    end
  end

  // Released pins show no stale value, so a late sample cannot pass
  always @(posedge read_strobe_n_i or posedge ce_n_i) #8 data_o = ~data_o;
endmodule
`default_nettype wire

//--- test/nand_host_bench.sv
// Self-checking bench: host sequencer against the behavioural flash.
// Assumes the package, design files, flash model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module nand_host_bench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic bus16_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic wr_valid_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  nand_host_pkg::req_t req_i = '0;
  logic req_ready_o, wr_ready_o, rd_valid_o, done_o, busy_o, ce_n_o, cle_o, ale_o, we_n_o;
  logic read_strobe_n_o, wp_n_o, shared_data_pins_oe_o, pull_low, ready_busy_n;
  logic [15:0] rd_data_o, shared_data_pins_o, flash_q, pins, mask;
  logic [15:0] got_q[$];
  logic [15:0] wd_q[$];
  logic [15:0] first_cmd [3] = '{16'h0000, 16'h0080, 16'h0060};
  logic [15:0] go_cmd [3] = '{16'h0030, 16'h0010, 16'h00d0};
  int err_total = 0, checks_done = 0, seed = 36550, cyc = 0, commits_ex = 0, room;

  // Open-drain ready line with pull-up; pins resolved from both drivers
  assign ready_busy_n = !pull_low;
  assign pins = shared_data_pins_oe_o ? shared_data_pins_o : flash_q;
  assign mask = bus16_i ? 16'hffff : 16'h00ff;

  nand_host nand_host_i (
    .clk_i(clk_i), .srst_i(srst_i), .bus16_i(bus16_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .done_o(done_o), .busy_o(busy_o), .ce_n_o(ce_n_o),
    .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .read_strobe_n_o(read_strobe_n_o),
    .wp_n_o(wp_n_o), .shared_data_pins_o(shared_data_pins_o),
    .shared_data_pins_oe_o(shared_data_pins_oe_o), .shared_data_pins_i(pins),
    .ready_busy_n_i(ready_busy_n));

  nand_flash_model nand_flash_model_i (
    .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .read_strobe_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .bus16_i(bus16_i),
    .pins_i(pins), .data_o(flash_q), .pull_low_o(pull_low));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and read-word collector
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  always @(posedge clk_i) if (rd_valid_o === 1'b1) got_q.push_back(rd_data_o);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Push words until the buffer refuses; nothing drains it meanwhile
  task automatic fill();
    int cnt = 0;
    wr_valid_i = 1'b1;
    wr_data_i = 16'($random(seed));
    repeat (24) begin
      @(posedge clk_i);
      if (wr_ready_o === 1'b1) begin
        wd_q.push_back(wr_data_i);
        cnt++;
      end
      #1 wr_data_i = 16'($random(seed));
    end
    wr_valid_i = 1'b0;
    `CHK("fifo depth", 16, cnt)
    `CHK("fifo full", 1'b0, wr_ready_o)
  endtask

  // One request end to end, then compare what the flash saw and returned
  task automatic xfer(input nand_host_pkg::op_t op, input int col, input int row,
                      input int len);
    int n;
    int k;
    n = (op == nand_host_pkg::OP_ERASE) ? 0 : ((col + len > room) ? room - col : len);
    k = (op == nand_host_pkg::OP_ERASE) ? 0 : 2;
    nand_flash_model_i.cmd_q.delete();
    nand_flash_model_i.addr_q.delete();
    nand_flash_model_i.data_q.delete();
    got_q.delete();
    req_i = '{op, col[11:0], row[15:0], len[11:0]};
    req_valid_i = 1'b1;
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    #1 req_valid_i = 1'b0;
    do begin @(posedge clk_i); #1; end while (done_o !== 1'b1);
    `CHK("select released", 1'b1, ce_n_o)
    `CHK("busy at done", 1'b1, busy_o)
    `CHK("command count", 2, nand_flash_model_i.cmd_q.size())
    `CHK("first command", first_cmd[op], nand_flash_model_i.cmd_q[0])
    `CHK("go command", go_cmd[op], nand_flash_model_i.cmd_q[1])
    `CHK("address count", k + 2, nand_flash_model_i.addr_q.size())
    if (k == 2) begin
      `CHK("column low", {8'h00, col[7:0]}, nand_flash_model_i.addr_q[0])
      `CHK("column high", bus16_i ? {13'h0000, col[10:8]} : {12'h000, col[11:8]},
           nand_flash_model_i.addr_q[1])
    end
    `CHK("row low", {8'h00, row[7:0]}, nand_flash_model_i.addr_q[k])
    `CHK("row high", {8'h00, row[15:8]}, nand_flash_model_i.addr_q[k + 1])
    if (op == nand_host_pkg::OP_READ) begin
      `CHK("word count", n, got_q.size())
      for (int i = 0; i < n && i < got_q.size(); i++) begin
        // Narrow bus must hand back the upper byte as zero, so no mask on the seen word
        `CHK("read word", 16'((col + i) * 261 + 15450) & mask, got_q[i])
      end
    end else begin
      commits_ex++;
      `CHK("commits", commits_ex, nand_flash_model_i.commits)
    end
    if (op == nand_host_pkg::OP_PROG) begin
      `CHK("data count", n, nand_flash_model_i.data_q.size())
      for (int i = 0; i < n; i++) begin
        `CHK("program word", wd_q[i] & mask, nand_flash_model_i.data_q[i])
      end
      repeat (n) void'(wd_q.pop_front());
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: both widths, read mid page and at page end, program, erase
  initial begin
    repeat (4) @(posedge clk_i);
    #1 srst_i = 1'b0;
    `CHK("idle select", 1'b1, ce_n_o)
    `CHK("idle protect", 1'b0, wp_n_o)
    `CHK("idle drive", 1'b0, shared_data_pins_oe_o)
    `CHK("idle busy", 1'b0, busy_o)
    for (int w = 0; w < 2; w++) begin
      bus16_i = w[0];
      room = w ? 1056 : 2112;
      xfer(nand_host_pkg::OP_READ, $random(seed) & 32'h1ff, $random(seed), 5);
      xfer(nand_host_pkg::OP_READ, room - 2, $random(seed), 5);
      fill();
      xfer(nand_host_pkg::OP_PROG, $random(seed) & 32'h1ff, $random(seed), 16);
      `CHK("fifo drained", 1'b1, wr_ready_o)
      xfer(nand_host_pkg::OP_ERASE, 0, $random(seed), 0);
      $display("width test %0d finished", w);
    end
    stop_test();
  end
endmodule
`default_nettype wire
